// [core/adcc_consts.svh]
/*
 * register offsets, field positions, reset values and timing counts
 * of the converter control block; definitions only.
 * assumes a 10 MHz clock for the derived cycle counts.
 */
`ifndef ADCC_CONSTS_SVH
`define ADCC_CONSTS_SVH

// ------------------------------------------------------------
// register map (byte addresses on the 32-bit bus)
// ------------------------------------------------------------
`define ADCC_OFF_CSR      12'h000
`define ADCC_OFF_RESULT   12'h004
`define ADCC_OFF_ISTAT    12'h008
`define ADCC_OFF_IMASK    12'h00C

// ------------------------------------------------------------
// field positions and reset values
// ------------------------------------------------------------
`define ADCC_BIT_DONE     7
`define ADCC_BIT_ON       5
`define ADCC_CSR_RST      8'h00
`define ADCC_RESULT_RST   8'h00
`define ADCC_EV_DONE      0
`define ADCC_EV_OVERRUN   1

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define ADCC_CLK_HZ       10000000
`define ADCC_STAB_NS      30000
`define ADCC_CLK_MHZ      (`ADCC_CLK_HZ / 1000000)
`define ADCC_STAB_CYC     ((`ADCC_STAB_NS * `ADCC_CLK_MHZ + 999) / 1000)
`define ADCC_CONV_CYC     64
`define ADCC_SAMPLE_CYC   32

`endif

// [core/adcc_pkg.sv]
/*
 * types shared by the converter control block.
 * assumes adcc_consts.svh for the numeric constants.
 */
package adcc_pkg;

    // converter sequencer, one-hot
    typedef enum logic [3:0] {
        ADCC_OFF    = 4'b0001,
        ADCC_STAB   = 4'b0010,
        ADCC_SAMPLE = 4'b0100,
        ADCC_CONV   = 4'b1000
    } adcc_state_t;

    // control/status register image
    typedef struct packed {
        logic       done;
        logic       rsv6;
        logic       on;
        logic       rsv4;
        logic       rsv3;
        logic [2:0] chan;
    } adcc_csr_t;

endpackage : adcc_pkg

// [core/adcc_top.sv]
/*
 * control logic of an 8-bit successive-approximation converter:
 * apb register slave, stabilisation timer, 64-cycle conversion
 * sequencer, result register and a sticky/masked event output.
 * assumes an external analog mux, sample switch, dac and a
 * comparator whose output is high while input >= trial code.
 */
// Decided for this implementation: the APB interface to the registers and the address map.
// What this block does
// - each finished conversion is stored as an 8-bit unsigned result
// - channel_select bits 2:0 pick analog input 0 through 7
// - after converter_on, wait about 30 us then convert continuously
// - one conversion lasts 64 cycles, the first ~31.5 sampling
// - done sets conversion_done_flag bit 7; irq_o signals masked done/overrun events
// - reading the result or writing the csr clears the done flag
// - a csr write aborts and restarts conversion with new settings
// - converter_on is software-only; while 0 nothing converts
// - inputs above/below references give FFh/00h, no overflow flag
// - wait mode does not affect the converter
// - halt disables it; after halt stabilisation is repeated
// - bit 4 of the csr always reads 0
// - result register is read-only and resets to zero
`timescale 1ns/100ps
`include "adcc_consts.svh"

module adcc_top
    import adcc_pkg::*;
#(
    parameter int STAB_CYC = `ADCC_STAB_CYC
) (
    // clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        arst_n_i,
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // power mode from the system controller
    input  wire logic        halt_i,
    // analog front end
    output logic      [2:0]  chan_sel_o,
    output logic             conv_on_o,
    output logic             sample_o,
    output logic      [7:0]  trial_code_o,
    input  wire logic        cmp_i,
    // event interrupt
    output logic             irq_o
);

    // the stabilisation counter is 16 bits; refuse what it cannot count
    if (STAB_CYC < 1 || STAB_CYC > 65535) begin : g_stab_check
        $error("STAB_CYC out of range");
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] onehot8(input logic [2:0] idx);
        onehot8 = 8'h01 << idx;
    endfunction : onehot8

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    logic [31:0] prdata_reg;
    adcc_csr_t   csr_reg;
    logic [7:0]  result_reg;
    logic [1:0]  istat_reg;
    logic [1:0]  imask_reg;
    wire         setup     = psel_i & ~penable_i;
    wire         access    = psel_i & penable_i;
    wire         hit_csr   = paddr_i == `ADCC_OFF_CSR;
    wire         hit_res   = paddr_i == `ADCC_OFF_RESULT;
    wire         hit_ist   = paddr_i == `ADCC_OFF_ISTAT;
    wire         hit_msk   = paddr_i == `ADCC_OFF_IMASK;
    wire         mapped    = hit_csr | hit_res | hit_ist | hit_msk;
    wire         wr_csr    = access & pwrite_i & hit_csr;
    wire         rd_res    = access & ~pwrite_i & hit_res;
    wire         wr_ist    = access & pwrite_i & hit_ist;
    wire         wr_msk    = access & pwrite_i & hit_msk;
    wire [31:0]  rd_mux    = hit_csr ? {24'h000000, csr_reg} :
                             hit_res ? {24'h000000, result_reg} :
                             hit_ist ? {30'h00000000, istat_reg} :
                             hit_msk ? {30'h00000000, imask_reg} :
                             32'h00000000;

    // read data captured in setup so the answer comes from a flop
    assign pready_o  = access;
    assign pslverr_o = access & ~mapped;
    assign prdata_o  = prdata_reg;

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prdata_reg <= 32'h00000000;
        end else if (setup) begin
            prdata_reg <= rd_mux;
        end
    end

    // ------------------------------------------------------------
    // comparator synchroniser (3 flops, 2nd and 3rd must agree)
    // ------------------------------------------------------------
    logic [2:0] cmp_sync_reg;
    logic       cmp_hold_reg;
    wire        cmp_agree = cmp_sync_reg[1] == cmp_sync_reg[2];
    wire        cmp_val   = cmp_agree ? cmp_sync_reg[2] : cmp_hold_reg;

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cmp_sync_reg <= 3'h0;
            cmp_hold_reg <= 1'b0;
        end else begin
            cmp_sync_reg <= {cmp_sync_reg[1:0], cmp_i};
            cmp_hold_reg <= cmp_val;
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    adcc_state_t state_reg, state_next;
    logic [15:0] stab_cnt_reg;
    logic [5:0]  cyc_reg;
    logic [7:0]  trial_reg;
    // a csr write restarts; halt or converter off stops everything
    wire         run       = csr_reg.on & ~halt_i;
    wire         stab_end  = stab_cnt_reg == 16'(STAB_CYC - 1);
    wire         samp_end  = cyc_reg == 6'(`ADCC_SAMPLE_CYC - 1);
    wire         bit_slot  = cyc_reg[1:0] == 2'h3;
    wire [2:0]   bit_idx   = ~cyc_reg[4:2];
    wire         conv_end  = cyc_reg == 6'(`ADCC_CONV_CYC - 1);
    // keep the trial bit when the input is at or above the trial
    wire [7:0]   kept      = cmp_val ? trial_reg :
                             trial_reg & ~onehot8(bit_idx);
    wire         conv_done = (state_reg == ADCC_CONV) & conv_end & run
                             & ~wr_csr;
    wire         restart   = wr_csr & pwdata_i[`ADCC_BIT_ON] & ~halt_i
                             & (state_reg != ADCC_OFF)
                             & (state_reg != ADCC_STAB);

    // next state; halt drops to off so wakeup re-runs stabilisation
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ADCC_OFF: begin
                if (run) state_next = ADCC_STAB;
            end
            ADCC_STAB: begin
                if (!run) state_next = ADCC_OFF;
                else if (stab_end) state_next = ADCC_SAMPLE;
            end
            ADCC_SAMPLE: begin
                if (!run) state_next = ADCC_OFF;
                else if (samp_end) state_next = ADCC_CONV;
            end
            ADCC_CONV: begin
                if (!run) state_next = ADCC_OFF;
                else if (conv_end) state_next = ADCC_SAMPLE;
            end
        endcase
        if (restart) state_next = ADCC_SAMPLE;
        if (wr_csr && !pwdata_i[`ADCC_BIT_ON]) state_next = ADCC_OFF;
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_reg <= ADCC_OFF;
        end else begin
            state_reg <= state_next;
        end
    end

    // stabilisation counter runs only while waiting
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            stab_cnt_reg <= 16'h0000;
        end else if (state_reg == ADCC_STAB && run) begin
            stab_cnt_reg <= stab_cnt_reg + 16'h0001;
        end else begin
            stab_cnt_reg <= 16'h0000;
        end
    end

    // conversion cycle counter, 0..63, sampling occupies 0..31
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cyc_reg <= 6'h00;
        // a restart inside sampling must rewind the count as well
        end else if (restart || (state_next == ADCC_SAMPLE
                     && state_reg != ADCC_SAMPLE)) begin
            cyc_reg <= 6'h00;
        end else if (state_reg == ADCC_SAMPLE
                     || state_reg == ADCC_CONV) begin
            cyc_reg <= cyc_reg + 6'h01;
        end else begin
            cyc_reg <= 6'h00;
        end
    end

    // successive approximation, four cycles per bit, msb first
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            trial_reg <= 8'h00;
        end else if (state_reg == ADCC_SAMPLE && samp_end) begin
            trial_reg <= 8'h80;
        end else if (state_reg == ADCC_CONV && bit_slot) begin
            if (bit_idx != 3'h0) begin
                trial_reg <= kept | onehot8(3'(bit_idx - 3'h1));
            end else begin
                trial_reg <= kept;
            end
        end
    end

    // ------------------------------------------------------------
    // result and control/status
    // ------------------------------------------------------------
    // read-only result, overwritten by every conversion
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            result_reg <= `ADCC_RESULT_RST;
        end else if (conv_done) begin
            result_reg <= kept;
        end
    end

    // done flag: hardware set wins over a result read
    wire done_next = conv_done ? 1'b1 :
                     (rd_res | wr_csr) ? 1'b0 :
                     csr_reg.done;

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            csr_reg <= `ADCC_CSR_RST;
        end else begin
            csr_reg.done <= done_next;
            if (wr_csr) begin
                csr_reg.on   <= pwdata_i[`ADCC_BIT_ON];
                csr_reg.chan <= pwdata_i[2:0];
                csr_reg.rsv6 <= pwdata_i[6];
                csr_reg.rsv3 <= pwdata_i[3];
            end
            csr_reg.rsv4 <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // events: done and overrun, write one to clear, set wins
    // ------------------------------------------------------------
    wire [1:0] ev_set = {conv_done & csr_reg.done, conv_done};
    wire [1:0] ev_clr = wr_ist ? pwdata_i[1:0] : 2'h0;

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            istat_reg <= 2'h0;
            imask_reg <= 2'h0;
        end else begin
            istat_reg <= (istat_reg & ~ev_clr) | ev_set;
            if (wr_msk) imask_reg <= pwdata_i[1:0];
        end
    end

    // level output; masks reset closed so nothing fires unasked
    assign irq_o = |(istat_reg & imask_reg);

    // ------------------------------------------------------------
    // analog front end drive
    // ------------------------------------------------------------
    // halt only, never wait, gates power: wait has no input here
    assign conv_on_o    = run;
    assign chan_sel_o   = csr_reg.chan;
    assign sample_o     = state_reg == ADCC_SAMPLE;
    assign trial_code_o = trial_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // cycles since the last completion; a csr write or a stop breaks the
    // chain, so only undisturbed back-to-back conversions are timed
    logic [6:0] since_done_reg;
    logic       chain_reg;

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            since_done_reg <= 7'h00;
            chain_reg      <= 1'b0;
        end else if (conv_done) begin
            since_done_reg <= 7'h00;
            chain_reg      <= 1'b1;
        end else if (wr_csr || !run) begin
            chain_reg      <= 1'b0;
        end else if (since_done_reg != 7'h7F) begin
            since_done_reg <= since_done_reg + 7'h01;  // saturates, no wrap
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);

    a_rsv_bit_zero: assert property (!csr_reg.rsv4)
        else $error("reserved bit 4 set");
    a_done_sets: assert property (conv_done |=> csr_reg.done)
        else $error("done flag not set");
    a_done_clear: assert property (
        (rd_res || wr_csr) && !conv_done |=> !csr_reg.done)
        else $error("done flag not cleared");
    a_result_load: assert property (
        conv_done |=> result_reg == $past(kept))
        else $error("result not stored");
    a_off_idle: assert property (
        !csr_reg.on |=> state_reg inside {ADCC_OFF})
        else $error("converting while off");
    // sampling ends after cycle 31 unless a write or a stop cut it short
    a_sample_len: assert property (
        $fell(sample_o) && $past(run && !wr_csr)
        |-> $past(cyc_reg) == 6'h1F)
        else $error("sampling not 32 cycles");
    // sampling may only follow a full stabilisation count
    a_stab_wait: assert property (
        $rose(sample_o) && $past(state_reg == ADCC_STAB)
        |-> $past(stab_cnt_reg) == 16'(STAB_CYC - 1))
        else $error("no stabilisation");
    a_conv_period: assert property (
        conv_done && chain_reg |-> since_done_reg == 7'h3F)
        else $error("conversion not 64 cycles");
    a_csr_restart: assert property (
        restart |=> state_reg == ADCC_SAMPLE && cyc_reg == 6'h00)
        else $error("no restart");
    a_halt_stop: assert property (halt_i |=> !sample_o)
        else $error("converting in halt");
    a_overwrite: assert property (
        conv_done && csr_reg.done |=> istat_reg[1])
        else $error("overrun not flagged");

    c_first_result: cover property ($rose(csr_reg.done));
    c_back_to_back: cover property (conv_done ##64 conv_done);
    c_restart: cover property (restart);
    c_full_scale: cover property (conv_done && kept == 8'hFF);
    c_halt_wake: cover property ($fell(halt_i) ##1 state_reg == ADCC_STAB);

endmodule : adcc_top

// [verification/adcc_afe_model.sv]
/* analog front end model: input mux, sample-and-hold, comparator.
   assumes per-channel levels from the bench, 255 = upper reference. */
`timescale 1ns/100ps
module adcc_afe_model (
    // clock
    input  wire logic            clk_i,
    // converter controls
    input  wire logic [2:0]      chan_i,
    input  wire logic            on_i,
    input  wire logic            sample_i,
    input  wire logic [7:0]      trial_i,
    input  wire logic [7:0][8:0] level_i,
    // comparator
    output logic                 cmp_o
);
    logic [8:0] held_reg;
    logic       noise_reg = 1'b0;
    // hold tracks the selected input only while the switch is closed
    always_ff @(posedge clk_i) begin
        held_reg  <= (sample_i && on_i) ? level_i[chan_i] : held_reg;
        noise_reg <= ~noise_reg;
    end
    // powered down: output toggles, never a stale decision
    assign cmp_o = on_i ? ({1'b0, trial_i} <= held_reg) : noise_reg;
endmodule : adcc_afe_model

// [verification/test_adc_conversion_control.sv]
/* self-checking bench of the converter control block over apb.
   assumes adcc_afe_model as the analog side and a shortened delay. */
`timescale 1ns/100ps
`include "adcc_consts.svh"
module test_adc_conversion_control;
    import adcc_pkg::*;
    localparam int STAB  = 4;
    localparam int LIMIT = 20000;
    logic            ref_clk_i = 1'b0;
    logic            arst_n_i  = 1'b0;
    logic            psel      = 1'b0;
    logic            penable   = 1'b0;
    logic            pwrite    = 1'b0;
    logic            halt      = 1'b0;
    logic [11:0]     paddr     = 12'h000;
    logic [31:0]     pwdata    = 32'h0;
    logic [31:0]     prdata;
    logic [31:0]     rd;
    logic            pready;
    logic            pslverr;
    logic            err;
    logic            conv_on;
    logic            sample;
    logic            cmp;
    logic            irq;
    logic [2:0]      chan;
    logic [7:0]      trial;
    logic [7:0][8:0] level;
    int n_mismatch  = 0;
    int checks_done = 0;
    int cyc = 0;
    int rises = 0;
    int rise_at = 0;
    int period = 0;
    int hi_len = 0;
    int run = 0;
    int n;
    int t0;

    adcc_top #(.STAB_CYC(STAB)) i_dut (
        .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .halt_i(halt),
        .chan_sel_o(chan), .conv_on_o(conv_on), .sample_o(sample),
        .trial_code_o(trial), .cmp_i(cmp), .irq_o(irq));
    adcc_afe_model i_afe (
        .clk_i(ref_clk_i), .chan_i(chan), .on_i(conv_on),
        .sample_i(sample), .trial_i(trial), .level_i(level),
        .cmp_o(cmp));

    always #50 ref_clk_i = ~ref_clk_i;
    // sampling window monitor on the falling edge, clear of launch races
    always @(negedge ref_clk_i) begin
        cyc++;
        if (sample === 1'b1 && run == 0) begin
            period  = cyc - rise_at;
            rise_at = cyc;
            rises++;
        end
        if (sample === 1'b1) run++;
        else if (run != 0) begin
            hi_len = run;
            run    = 0;
        end
        if (cyc == LIMIT) begin
            n_mismatch++;
            complete_run();
        end
    end

    // ----------------------------------------
    // bus and check tasks
    // ----------------------------------------
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge ref_clk_i);
        penable <= 1'b1;
        // no wait-state count assumed; only the global limit ends this
        do begin
            @(posedge ref_clk_i);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // poll the done flag; a dead sequencer runs into the global limit
    task wait_done();
        do begin
            apb(1'b0, `ADCC_OFF_CSR, 32'h0);
        end while (rd[7] !== 1'b1);
    endtask : wait_done
    function automatic logic [31:0] expv(input int ch);
        return (level[ch] > 9'd255) ? 32'hFF : {23'h0, level[ch]};
    endfunction : expv
    task complete_run();
        $display("checks=%0d mismatches=%0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : complete_run

    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        for (int i = 0; i < 8; i++) level[i] = 9'(i * 37 + 3);
        level[0] = 9'h000;
        level[7] = 9'h190;
        repeat (3) @(posedge ref_clk_i);
        arst_n_i <= 1'b1;
        apb(1'b0, `ADCC_OFF_CSR, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, `ADCC_OFF_RESULT, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, `ADCC_OFF_IMASK, 32'h0);
        chk(irq, 32'h0);
        $display("test reset done");
        // every channel code, reserved bits 6 and 3 kept at zero
        for (int c = 0; c < 8; c++) begin
            apb(1'b1, `ADCC_OFF_CSR, 32'h20 | c);
            wait_done();
            chk(chan, c);
            apb(1'b0, `ADCC_OFF_RESULT, 32'h0);
            chk(rd, expv(c));
            apb(1'b0, `ADCC_OFF_CSR, 32'h0);
            chk(rd, 32'h20 | c);
        end
        apb(1'b1, `ADCC_OFF_RESULT, 32'hAA);
        apb(1'b0, `ADCC_OFF_RESULT, 32'h0);
        chk(rd, expv(7));
        $display("test channels done");
        // unread results pile up: overwrite and the overrun event;
        // the level output is looked at mid-cycle, clear of its launch
        apb(1'b1, `ADCC_OFF_IMASK, 32'h2);
        @(negedge ref_clk_i);
        chk(irq, 32'h0);
        level[7] = 9'h05A;
        repeat (140) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        chk(irq, 32'h1);
        apb(1'b0, `ADCC_OFF_CSR, 32'h0);
        chk(rd, 32'hA7);
        apb(1'b0, `ADCC_OFF_RESULT, 32'h0);
        chk(rd, 32'h5A);
        apb(1'b1, `ADCC_OFF_ISTAT, 32'h2);
        @(negedge ref_clk_i);
        chk(irq, 32'h0);
        chk(hi_len, 32'd32);
        chk(period, 32'd64);
        $display("test continuous done");
        // abort in mid-sampling with a new channel
        apb(1'b1, `ADCC_OFF_CSR, 32'h22);
        repeat (10) @(posedge ref_clk_i);
        apb(1'b1, `ADCC_OFF_CSR, 32'h25);
        apb(1'b0, `ADCC_OFF_CSR, 32'h0);
        chk(rd, 32'h25);
        wait_done();
        apb(1'b0, `ADCC_OFF_RESULT, 32'h0);
        chk(rd, expv(5));
        $display("test abort done");
        // switched off, reserved bit 4 written
        apb(1'b1, `ADCC_OFF_CSR, 32'h17);
        repeat (2) @(posedge ref_clk_i);
        chk(conv_on, 32'h0);
        n = rises;
        repeat (150) @(posedge ref_clk_i);
        chk(rises - n, 32'h0);
        apb(1'b0, `ADCC_OFF_CSR, 32'h0);
        chk(rd, 32'h07);
        $display("test off done");
        // halt stops the converter; wake-up repeats stabilisation
        apb(1'b1, `ADCC_OFF_CSR, 32'h21);
        wait_done();
        apb(1'b0, `ADCC_OFF_RESULT, 32'h0);
        halt <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        chk(conv_on, 32'h0);
        n = rises;
        repeat (100) @(posedge ref_clk_i);
        chk(rises - n, 32'h0);
        halt <= 1'b0;
        t0 = cyc;
        repeat (300) @(posedge ref_clk_i) if (rises != n) break;
        chk(rise_at - t0 >= STAB, 32'h1);
        wait_done();
        apb(1'b0, `ADCC_OFF_RESULT, 32'h0);
        chk(rd, expv(1));
        $display("test halt done");
        apb(1'b0, 12'h010, 32'h0);
        chk(err, 32'h1);
        chk(rd, 32'h0);
        $display("test unmapped done");
        complete_run();
    end
endmodule : test_adc_conversion_control
